/* rtl/apmc_device.sv */
// converter end: control word, power-down, sequencer, result memory
//
// Behaviour
// R1: static-high clock pin selects internal oscillator, 165us start
// R2: external clock duty stays 30 to 70 percent
// R3: reset leaves interrupt high, bank A single
// R4: 5us internal reset; no conversions during it
// R5: result memory undefined until first sequence
// R6: power-down bit set enters software power-down
// R7: power-down takes effect at write end edge
// R8: core off in power-down; interface keeps working
// R9: write with power-down bit clear wakes device
// R10: wake resumes in mode of same word
// R11: host waits 20ms after wake-up; apmc_host only flags the window in status, does not hold starts
// R12: results are twelve-bit two's complement codes
// R13: code steps at integer LSB multiples
// R14: external demux makes four reads, one latch
// R15: demux holds chip select low throughout burst
// R16: two-bit input selects latched channel
// R17: control word captured at write-ending rising edge
// R18: converts one to four bank channels per start
// R19: interrupt driven low after last conversion
// R20: read pointer returns to first channel after four
// R21: starts ignored in reset or power-down
// R22: external clock used unless pin static high
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module apmc_device (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link
  apmc_if.device           lnk,
  // analog side: signed sample per channel of each bank
  input  wire logic [11:0] sample_a [4],
  input  wire logic [11:0] sample_b [4],
  // status
  output logic             powered_down,
  output logic             osc_internal,
  output logic             busy
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic        cs_n_s, wr_n_s, rd_n_s, st_n_s, ck_s;
  logic [11:0] bus_s;

  apmc_sync #(.W(17), .INIT(apmc_pkg::DEV_SYNC_IDLE)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({lnk.cs_n, lnk.wr_n, lnk.rd_n, lnk.sample_start_n, lnk.ext_clk, lnk.bus}),
    .q   ({cs_n_s, wr_n_s, rd_n_s, st_n_s, ck_s, bus_s})
  );

  logic wr_act_q, rd_act_q, st_n_q;
  wire  wr_act = !cs_n_s && !wr_n_s;
  wire  rd_act = !cs_n_s && !rd_n_s;
  // write ends at whichever of strobe or select rises first
  wire  wr_end = wr_act_q && !wr_act;                                   // [R17]
  wire  rd_end = rd_act_q && !rd_act;
  wire  rd_beg = !rd_act_q && rd_act;
  wire  st_rise = !st_n_q && st_n_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      st_n_q   <= 1'b1;
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      st_n_q   <= st_n_s;
    end
  end

  // bus is released with the strobe, so keep the last word seen while writing
  logic [11:0] wr_data_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_data_q <= 12'h000;
    end else if (wr_act) begin
      wr_data_q <= bus_s;                                               // [R17]
    end
  end

  // ****************************************************************
  // clock source selection
  // ****************************************************************
  logic [4:0]  static_cnt_q;
  logic [15:0] osc_cnt_q;
  logic        osc_ready_q;

  always_ff @(posedge clk) begin
    if (rst || !ck_s) begin
      static_cnt_q <= 5'h00;
    end else if (static_cnt_q != 5'(apmc_pkg::CLKSTATIC_CYC)) begin
      static_cnt_q <= static_cnt_q + 5'h01;
    end
  end

  assign osc_internal = (static_cnt_q == 5'(apmc_pkg::CLKSTATIC_CYC));  // [R22]

  // oscillator startup before the sequencer may use it
  always_ff @(posedge clk) begin
    if (rst || !osc_internal) begin
      osc_cnt_q   <= 16'h0000;
      osc_ready_q <= 1'b0;
    end else if (osc_cnt_q == 16'(apmc_pkg::OSC_START_CYC - 1)) begin
      osc_ready_q <= 1'b1;                                              // [R1]
    end else begin
      osc_cnt_q <= osc_cnt_q + 16'h0001;
    end
  end

  // external clock rising edges give a conversion tick; internal runs every cycle
  logic ck_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      ck_q <= 1'b1;
    end else begin
      ck_q <= ck_s;
    end
  end
  wire conv_tick = osc_internal ? osc_ready_q : (ck_s && !ck_q);

  // ****************************************************************
  // internal reset window
  // ****************************************************************
  logic [9:0] por_cnt_q;
  wire        in_por = (por_cnt_q != 10'(apmc_pkg::POR_RESET_CYC));

  always_ff @(posedge clk) begin
    if (rst) begin
      por_cnt_q <= 10'h000;
    end else if (in_por) begin
      por_cnt_q <= por_cnt_q + 10'h001;                                 // [R4]
    end
  end

  // ****************************************************************
  // control word
  // ****************************************************************
  logic [1:0] mode_q;
  logic       bank_q;
  logic       pd_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= apmc_pkg::CTRL_RESET[1:0];                              // [R3]
      bank_q <= apmc_pkg::CTRL_RESET[apmc_pkg::BANK_SELECT_POS];
      pd_q   <= apmc_pkg::CTRL_RESET[apmc_pkg::POWER_DOWN_POS];
    end else if (wr_end) begin
      pd_q <= wr_data_q[apmc_pkg::POWER_DOWN_POS];                      // [R6] [R7] [R9]
      // power-down word is don't-care on the mode bits
      if (!wr_data_q[apmc_pkg::POWER_DOWN_POS]) begin
        mode_q <= {wr_data_q[apmc_pkg::MODE_BIT1_POS],
                   wr_data_q[apmc_pkg::MODE_BIT0_POS]};                 // [R10]
        bank_q <= wr_data_q[apmc_pkg::BANK_SELECT_POS];
      end
    end
  end

  assign powered_down = pd_q;

  // ****************************************************************
  // sequencer and result memory
  // ****************************************************************
  typedef enum logic [1:0] {APMC_IDLE, APMC_CONV} apmc_seq_t;
  apmc_seq_t   seq_q;
  logic [1:0]  conv_ch_q;
  logic [7:0]  tick_cnt_q;
  logic [11:0] mem_q [4];                                               // [R5]
  logic [1:0]  rd_ptr_q;
  logic        int_n_q;
  logic [11:0] dout_q;
  logic [11:0] hold_q [4];
  wire         last_ch = ({1'b0, conv_ch_q} + 3'h1 == apmc_pkg::apmc_nch(mode_q));
  wire         start_ok = st_rise && !in_por && !pd_q && (seq_q == APMC_IDLE); // [R21]

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_q      <= APMC_IDLE;
      conv_ch_q  <= 2'h0;
      tick_cnt_q <= 8'h00;
    end else begin
      case (seq_q)
        APMC_IDLE: begin
          if (start_ok) begin
            seq_q      <= APMC_CONV;                                    // [R18]
            conv_ch_q  <= 2'h0;
            tick_cnt_q <= 8'h00;
          end
        end
        APMC_CONV: begin
          if (pd_q) begin
            seq_q <= APMC_IDLE;                                         // [R8]
          end else if (conv_tick) begin
            if (tick_cnt_q == 8'(apmc_pkg::CONV_CYC - 1)) begin
              tick_cnt_q <= 8'h00;
              if (last_ch) begin
                seq_q <= APMC_IDLE;
              end else begin
                conv_ch_q <= conv_ch_q + 2'h1;
              end
            end else begin
              tick_cnt_q <= tick_cnt_q + 8'h01;
            end
          end
        end
        default: seq_q <= APMC_IDLE;
      endcase
    end
  end

  wire conv_done = (seq_q == APMC_CONV) && !pd_q && conv_tick
                   && (tick_cnt_q == 8'(apmc_pkg::CONV_CYC - 1));

  // held samples taken at start, stored as two's complement codes
  always_ff @(posedge clk) begin
    if (start_ok) begin
      for (int i = 0; i < apmc_pkg::NUM_CH; i++) begin
        hold_q[i] <= bank_q ? sample_b[i] : sample_a[i];
      end
    end
    if (conv_done) begin
      mem_q[conv_ch_q] <= hold_q[conv_ch_q];                            // [R12] [R13]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int_n_q <= 1'b1;                                                  // [R3]
    end else if (conv_done && last_ch) begin
      int_n_q <= 1'b0;                                                  // [R19]
    end else if (rd_beg) begin
      int_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || start_ok) begin
      rd_ptr_q <= 2'h0;
    end else if (rd_end) begin
      rd_ptr_q <= rd_ptr_q + 2'h1;                                      // [R20]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dout_q <= 12'h000;
    end else begin
      dout_q <= mem_q[rd_ptr_q];
    end
  end

  assign lnk.int_n     = int_n_q;
  assign lnk.dev_dout  = dout_q;
  assign lnk.dev_doe_n = !rd_act;
  assign busy          = (seq_q == APMC_CONV);
endmodule : apmc_device

/* rtl/apmc_host.sv */
// host end: apb registers driving control writes, starts and demux reads
`timescale 1ns/1ns
module apmc_host (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  apmc_if.host             lnk
);
  // ****************************************************************
  // apb registers
  // ****************************************************************
  logic [3:0]  ctrl_q;
  logic [1:0]  sel_q;
  logic [11:0] data_q;
  logic        int_s;
  logic [11:0] bus_s;
  logic        go_wr, go_st, go_dm;
  wire         acc = psel && penable;
  wire         hit = (paddr == apmc_pkg::REG_CTRL) || (paddr == apmc_pkg::REG_STATUS)
                     || (paddr == apmc_pkg::REG_DATA) || (paddr == apmc_pkg::REG_CMD);

  apmc_sync #(.W(13), .INIT(apmc_pkg::HOST_SYNC_IDLE)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({lnk.int_n, lnk.bus}),
    .q   ({int_s, bus_s})
  );

  typedef enum logic [2:0] {H_IDLE, H_WR, H_ST, H_RD_LO, H_RD_HI} apmc_hst_t;
  apmc_hst_t  st_q;
  logic [3:0] div_q;
  logic [1:0] cnt_q;
  wire        tick = (div_q == 4'(apmc_pkg::DEMUX_DIV - 1));
  wire        idle = (st_q == H_IDLE);

  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign go_wr   = acc && pwrite && idle && (paddr == apmc_pkg::REG_CMD)
                   && pwdata[apmc_pkg::CMD_WRITE_POS];
  assign go_st   = acc && pwrite && idle && (paddr == apmc_pkg::REG_CMD)
                   && pwdata[apmc_pkg::CMD_START_POS];
  assign go_dm   = acc && pwrite && idle && (paddr == apmc_pkg::REG_CMD)
                   && pwdata[apmc_pkg::CMD_DEMUX_POS];

  // settling window after a wake-up word; software waits before trusting results
  logic        pd_sent_q;
  logic [20:0] wake_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pd_sent_q <= 1'b0;
      wake_q    <= 21'h00_0000;
    end else if (go_wr) begin
      pd_sent_q <= ctrl_q[apmc_pkg::POWER_DOWN_POS];
      if (pd_sent_q && !ctrl_q[apmc_pkg::POWER_DOWN_POS]) begin
        wake_q <= 21'(apmc_pkg::WAKE_DELAY_CYC);                        // [R11]
      end
    end else if (wake_q != 21'h00_0000) begin
      wake_q <= wake_q - 21'h00_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= apmc_pkg::CTRL_RESET;
      sel_q  <= 2'h0;
    end else if (acc && pwrite && paddr == apmc_pkg::REG_CTRL) begin
      ctrl_q <= pwdata[3:0];
      sel_q  <= pwdata[apmc_pkg::SEL_LSB +: 2];                         // [R16]
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      case (paddr)
        apmc_pkg::REG_CTRL:   prdata = {26'h000_0000, sel_q, ctrl_q};
        apmc_pkg::REG_STATUS: prdata = {29'h0000_0000, wake_q != 21'h00_0000, !idle, !int_s};
        apmc_pkg::REG_DATA:   prdata = {20'h0_0000, data_q};
        default:              prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // link sequencer, paced by the demux-rate enable
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst || idle) begin
      div_q <= 4'h0;
    end else begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;                              // [R14]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q  <= H_IDLE;
      cnt_q <= 2'h0;
    end else begin
      case (st_q)
        H_IDLE: begin
          cnt_q <= 2'h0;
          if (go_wr) st_q <= H_WR;
          else if (go_st) st_q <= H_ST;
          else if (go_dm && !int_s) st_q <= H_RD_LO;                    // [R14]
        end
        H_WR, H_ST: if (tick) st_q <= H_IDLE;
        H_RD_LO: if (tick) st_q <= H_RD_HI;
        H_RD_HI: begin
          if (tick) begin
            cnt_q <= cnt_q + 2'h1;
            st_q  <= (cnt_q == 2'(apmc_pkg::NUM_CH - 1)) ? H_IDLE : H_RD_LO;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // latch strobe: capture at end of the selected read's low phase
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= 12'h000;
    end else if (st_q == H_RD_LO && tick && cnt_q == sel_q) begin
      data_q <= bus_s;
    end
  end

  // ext_clk held high: device runs from its internal oscillator
  assign lnk.ext_clk        = 1'b1;                                     // [R2]
  assign lnk.cs_n           = !(st_q == H_WR || st_q == H_RD_LO || st_q == H_RD_HI); // [R15]
  assign lnk.wr_n           = !(st_q == H_WR);
  assign lnk.rd_n           = !(st_q == H_RD_LO);
  assign lnk.sample_start_n = !(st_q == H_ST);
  assign lnk.host_dout      = {8'h00, ctrl_q};
  assign lnk.host_doe_n     = !(st_q == H_WR);
endmodule : apmc_host

/* rtl/apmc_if.sv */
// parallel link between the converter control logic and its host
`timescale 1ns/1ns
interface apmc_if;
  logic        cs_n;
  logic        wr_n;
  logic        rd_n;
  logic        sample_start_n;
  logic        ext_clk;
  logic        int_n;
  logic [11:0] host_dout;
  logic        host_doe_n;
  logic [11:0] dev_dout;
  logic        dev_doe_n;
  logic [11:0] bus;

  // resolved bidirectional bus, pulled low when idle
  assign bus = !dev_doe_n ? dev_dout : (!host_doe_n ? host_dout : 12'h000);

  modport device (input cs_n, wr_n, rd_n, sample_start_n, ext_clk, bus,
                  output int_n, dev_dout, dev_doe_n);
  modport host   (output cs_n, wr_n, rd_n, sample_start_n, ext_clk, host_dout, host_doe_n,
                  input int_n, bus);
endinterface : apmc_if

/* rtl/apmc_pkg.sv */
// shared constants and types for the converter power/mode control block
package apmc_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int CLK_MHZ            = 100;
  localparam int OSC_START_US       = 165;
  localparam int POR_RESET_US       = 5;
  localparam int CONV_TIME_NS       = 2000;
  localparam int WAKE_DELAY_MS      = 20;
  localparam int DEMUX_CLK_MHZ      = 16;
  localparam int OSC_START_CYC      = OSC_START_US * CLK_MHZ;
  localparam int POR_RESET_CYC      = POR_RESET_US * CLK_MHZ;
  localparam int CONV_CYC           = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int WAKE_DELAY_CYC     = WAKE_DELAY_MS * 1000 * CLK_MHZ;
  // demux tick: shortest whole period not faster than the 16 MHz clock
  localparam int DEMUX_DIV          = (CLK_MHZ + DEMUX_CLK_MHZ - 1) / DEMUX_CLK_MHZ;
  localparam int CLKSTATIC_CYC      = 16;

  // ****************************************************************
  // widths and control word fields
  // ****************************************************************
  localparam int DATA_W             = 12;
  localparam int NUM_CH             = 4;
  localparam int MODE_BIT0_POS      = 0;
  localparam int MODE_BIT1_POS      = 1;
  localparam int BANK_SELECT_POS    = 2;
  localparam int POWER_DOWN_POS     = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // synchroniser reset levels: strobes and clock pin idle high, bus pulled low
  localparam logic [16:0] DEV_SYNC_IDLE  = 17'h1_f000;
  localparam logic [12:0] HOST_SYNC_IDLE = 13'h1000;

  // ****************************************************************
  // apb map of the host controller
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA   = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam int CMD_WRITE_POS      = 0;
  localparam int CMD_START_POS      = 1;
  localparam int CMD_DEMUX_POS      = 2;
  localparam int SEL_LSB            = 4;

  typedef enum logic [1:0] {APMC_CH1, APMC_CH2, APMC_CH3, APMC_CH4} apmc_ch_t;

  function automatic logic [2:0] apmc_nch(input logic [1:0] mode);
    return {1'b0, mode} + 3'h1;
  endfunction : apmc_nch

endpackage : apmc_pkg

/* rtl/apmc_sync.sv */
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ns
module apmc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      // idle level of each pin, so no false edge follows reset
      meta_q <= INIT;
      q      <= INIT;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : apmc_sync

/* testbench/adc_power_mode_control_tb_top.sv */
// self-checking bench joining host and device ends over the parallel link
`timescale 1ns/1ns
module adc_power_mode_control_tb_top;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        powered_down;
  logic        osc_internal;
  logic        busy;
  logic [11:0] samp_a [4];
  logic [11:0] samp_b [4];
  logic [32:0] exp_q [$];
  logic [32:0] msk_q [$];
  logic [31:0] rdat;
  int          pcyc;
  int          miscompares;
  int          num_checks;

  // ****************************************************************
  // design and checker
  // ****************************************************************
  apmc_if lnk ();
  apmc_device apmc_device_inst (.clk(clk), .rst(rst), .lnk(lnk), .sample_a(samp_a),
    .sample_b(samp_b), .powered_down(powered_down), .osc_internal(osc_internal), .busy(busy));
  apmc_host apmc_host_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lnk(lnk));
  apmc_assertions apmc_assertions_inst (.clk(clk), .rst(rst), .cs_n(lnk.cs_n),
    .wr_n(lnk.wr_n), .rd_n(lnk.rd_n), .sample_start_n(lnk.sample_start_n),
    .int_n(lnk.int_n), .host_doe_n(lnk.host_doe_n), .dev_doe_n(lnk.dev_doe_n));

  always #5 clk = ~clk;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // msk selects {pslverr, prdata} bits to compare; zero mask means poll only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] msk, input logic [32:0] exp);
    exp_q.push_back(exp & msk);
    msk_q.push_back(msk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdat = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h1_0000_0000, 33'h0_0000_0000);
  endtask : wr

  task automatic poll(input int bitn, input logic v);
    pcyc = 0;
    do begin
      apb(1'b0, apmc_pkg::REG_STATUS, 32'h0, 33'h0, 33'h0);
      pcyc += 3;
    end while (rdat[bitn] !== v && pcyc < 40000);
    check("status_poll", {32'h0, rdat[bitn]}, {32'h0, v});
  endtask : poll

  // one sequence: program, start, wait for completion, demux-read channel sel
  task automatic convert(input logic send, input logic [3:0] ctl, input logic [1:0] sel);
    logic [11:0] e;
    for (int i = 0; i < 4; i++) begin
      samp_a[i] <= 12'($urandom());
      samp_b[i] <= 12'($urandom());
    end
    @(posedge clk);
    e = ctl[2] ? samp_b[sel] : samp_a[sel];
    wr(apmc_pkg::REG_CTRL, {26'h0, sel, ctl});
    if (send) begin
      wr(apmc_pkg::REG_CMD, 32'h0000_0001);
      poll(1, 1'b0);
    end
    wr(apmc_pkg::REG_CMD, 32'h0000_0002);
    poll(0, 1'b1);
    check("conv_cycles", {32'h0, pcyc >= apmc_pkg::CONV_CYC * (ctl[1:0] + 1)}, 33'h1);
    wr(apmc_pkg::REG_CMD, 32'h0000_0004);
    poll(1, 1'b0);
    apb(1'b0, apmc_pkg::REG_DATA, 32'h0, 33'h0_0000_0fff, {21'h0, e});
    apb(1'b0, apmc_pkg::REG_STATUS, 32'h0, 33'h0_0000_0001, 33'h0);
  endtask : convert

  // ****************************************************************
  // response monitor and sequence
  // ****************************************************************
  always @(posedge clk) begin
    if (psel && penable && pready) begin
      if (msk_q.size() != 0 && msk_q[0] != 33'h0) begin
        check("apb_response", {pslverr, prdata} & msk_q[0], exp_q[0]);
      end
      if (msk_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    num_checks = 0;
    for (int i = 0; i < 4; i++) begin
      samp_a[i] = 12'h000;
      samp_b[i] = 12'h000;
    end
    void'($urandom(50490));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    check("int_n_reset", {32'h0, lnk.int_n}, 33'h1);
    check("pd_reset", {32'h0, powered_down}, 33'h0);
    wr(apmc_pkg::REG_CMD, 32'h0000_0002); // start inside the start-up window
    apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    repeat (1000) @(posedge clk);
    check("osc_internal", {32'h0, osc_internal}, 33'h1);
    check("por_start", {32'h0, busy}, 33'h0);
    apb(1'b0, apmc_pkg::REG_STATUS, 32'h0, 33'h0_0000_0001, 33'h0);
    repeat (17000) @(posedge clk);
    convert(1'b0, 4'h0, 2'h0);
    for (int m = 0; m < 8; m++) convert(1'b1, 4'(m), 2'(m));
    wr(apmc_pkg::REG_CTRL, 32'h0000_0008);
    wr(apmc_pkg::REG_CMD, 32'h0000_0001);
    poll(1, 1'b0);
    repeat (2) @(posedge clk);
    check("pd_enter", {32'h0, powered_down}, 33'h1);
    wr(apmc_pkg::REG_CMD, 32'h0000_0002);
    repeat (1000) @(posedge clk);
    apb(1'b0, apmc_pkg::REG_STATUS, 32'h0, 33'h0_0000_0001, 33'h0);
    convert(1'b1, 4'h5, 2'h1);
    apb(1'b0, apmc_pkg::REG_STATUS, 32'h0, 33'h0_0000_0004, 33'h0_0000_0004);
    check("pd_leave", {32'h0, powered_down}, 33'h0);
    complete_run();
  end
endmodule : adc_power_mode_control_tb_top

/* testbench/apmc_assertions.sv */
// concurrent checks on the parallel link between the host and device ends
`timescale 1ns/1ns
module apmc_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic sample_start_n,
  input wire logic int_n,
  input wire logic host_doe_n,
  input wire logic dev_doe_n
);
  // ****************************************************************
  // helper counters
  // ****************************************************************
  logic [15:0] since_rst_q;
  logic [15:0] since_start_q;

  // saturate so a long idle run never wraps into a false pass
  always_ff @(posedge clk) begin
    if (rst) since_rst_q <= 16'h0000;
    else if (since_rst_q != 16'hffff) since_rst_q <= since_rst_q + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (rst || !sample_start_n) since_start_q <= 16'h0000;
    else if (since_start_q != 16'hffff) since_start_q <= since_start_q + 16'h0001;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_int_high_a: assert property ($fell(rst) |-> int_n)
    else $error("interrupt low right after reset");
  no_contention_a: assert property (dev_doe_n || host_doe_n)
    else $error("both ends drive the bus");
  write_drive_a: assert property (!cs_n && !wr_n |-> !host_doe_n && dev_doe_n)
    else $error("bus not driven by host during write");
  write_width_a: assert property ($fell(wr_n) |-> (!wr_n && !cs_n) [*7] ##1 wr_n)
    else $error("write strobe width wrong");
  read_width_a: assert property ($fell(rd_n) |-> !rd_n [*7] ##1 rd_n)
    else $error("read strobe width wrong");
  read_select_a: assert property (!rd_n |-> !cs_n)
    else $error("read strobe without chip select");
  int_clear_a: assert property ($fell(rd_n) |-> ##[1:6] int_n)
    else $error("interrupt not cleared by read");
  conv_time_a: assert property ($fell(int_n) |-> since_start_q >= 16'h00c8)
    else $error("conversion finished too early");
  start_block_a: assert property ($fell(int_n) |-> since_rst_q > 16'h4074)
    else $error("conversion during start-up window");

  cover property ($fell(int_n));
  cover property ($fell(rd_n));
  cover property ($fell(wr_n));
endmodule : apmc_assertions
